// File: tlic_top.sv
// Two-level interrupt controller with a classic Wishbone register slave.
// Function
// - Wakeup enable bit gates wakeup interrupt.
// - Extended enable bits gate radio, SPI, ADC.
// - Extended enable/priority top three bits read one.
// - Extended priority bit four sets wakeup level.
// - Extended priority bits set radio, SPI, ADC level.
// - Accepted interrupt vectors CPU to fixed address.
// - Each source has its fixed vector address.
// - Same level ties resolved by natural order.
// - High level beats every low level request.
// - Preemption only by strictly higher level.
// - After return or mask write, one more instruction.
// - Return from interrupt releases active level.
// - Global enable bit masks all sources.
// - Extended pending flags and wakeup flag positions.
// - Timer and serial flags act as requests.
// - External pins sampled once per instruction cycle.
// - External pins active low, type bit selects.
// - Level type: flag set while pin low.
// - Edge type: flag set on high-then-low samples.
// - Extended flags set on rise, software clears.
// - Uncleared wakeup flag requests interrupt again.
// - Basic enable and priority bits for six sources.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module tlic_top (
	// Clock and reset
	input  wire logic                         clk_sys,
	input  wire logic                         arst_n,
	// Wishbone slave
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [tlic_pkg::ADR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [tlic_pkg::WB_DW-1:0]   wb_dat_i,
	output logic      [tlic_pkg::WB_DW-1:0]   wb_dat_o,
	output logic                              wb_ack_o,
	// CPU core
	input  wire logic                         fourth_clock_phase,
	input  wire logic                         instr_done_i,
	input  wire logic                         irq_take_i,
	input  wire logic                         reti_i,
	output logic                              irq_req_o,
	output logic      [tlic_pkg::REG_W-1:0]   irq_vector_o,
	output logic                              irq_level_o,
	// External pins, active low
	input  wire logic                         ext_irq0_pin_n,
	input  wire logic                         ext_irq1_pin_n,
	// On-chip sources
	input  wire logic                         timer0_flag_i,
	input  wire logic                         timer1_flag_i,
	input  wire logic                         serial_flag_i,
	input  wire logic                         timer2_flag_i,
	input  wire logic                         adc_eoc_i,
	input  wire logic                         spi_ready_i,
	input  wire logic                         radio_ready_one_i,
	input  wire logic                         radio_ready_two_i,
	input  wire logic                         wakeup_evt_i
);
	import tlic_pkg::*;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Lowest set index of a request mask, which is the natural winner.
	function automatic tlic_src_t pick_lowest(input logic [NSRC-1:0] m);
		tlic_src_t r;
		r = SRC_EXT0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = tlic_src_t'(i);
			end
		end
		return r;
	endfunction : pick_lowest

	// Fixed service routine address of each source.
	function automatic tlic_byte_t vec_of(input tlic_src_t s);
		tlic_byte_t v;
		v = VEC_NONE;
		unique case (s)
			SRC_EXT0: v = VEC_EXT0;
			SRC_TMR0: v = VEC_TMR0;
			SRC_EXT1: v = VEC_EXT1;
			SRC_TMR1: v = VEC_TMR1;
			SRC_SER:  v = VEC_SER;
			SRC_TMR2: v = VEC_TMR2;
			SRC_ADC:  v = VEC_ADC;
			SRC_SPI:  v = VEC_SPI;
			SRC_RAD1: v = VEC_RAD1;
			SRC_RAD2: v = VEC_RAD2;
			SRC_WAKE: v = VEC_WAKE;
			default:  v = VEC_NONE;
		endcase
		return v;
	endfunction : vec_of

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	tlic_byte_t             basic_enable_register_q;
	tlic_byte_t             basic_priority_register_q;
	tlic_byte_t             extended_interrupt_enable_q;
	tlic_byte_t             extended_interrupt_priority_q;
	logic [NEXT-1:0]        pin_meta_q;
	logic [NEXT-1:0]        pin_sync_q;
	logic [NEXT-1:0]        pin_prev_q;
	logic [NEXT-1:0]        ext_type_q;
	logic [NEXT-1:0]        ext_flag_q;
	logic [NXSRC-1:0]       xsrc_prev_q;
	logic [NXSRC-1:0]       xflag_q;
	logic                   wake_flag_q;
	logic                   ack_q;
	logic [WB_DW-1:0]       dat_q;
	logic                   hold_q;
	logic                   act_hi_q;
	logic                   act_lo_q;
	logic                   req_q;
	logic                   lvl_q;
	tlic_src_t              src_q;
	tlic_byte_t             vec_q;
	logic                   wb_req;
	logic                   wr_en;
	tlic_byte_t             wdat;
	tlic_byte_t             rd_byte;
	logic                   mask_wr;
	logic                   hold_ev;
	logic                   global_en;
	logic [NXSRC-1:0]       xsrc_now;
	logic [NXSRC-1:0]       xrise;
	logic [NEXT-1:0]        ext_fall;
	logic [NSRC-1:0]        pend;
	logic [NSRC-1:0]        en_all;
	logic [NSRC-1:0]        lvl_all;
	logic [NSRC-1:0]        cand_hi;
	logic [NSRC-1:0]        cand_lo;

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------

	// A request is answered one cycle after it appears, then ack drops.
	// Writes land at the edge where the master samples ack, while the request still stands.
	assign wb_req  = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr_en   = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
	assign wdat    = wb_dat_i[REG_W-1:0];
	assign mask_wr = wr_en & ((wb_adr_i == ADR_BASIC_EN) | (wb_adr_i == ADR_BASIC_PRI)
		| (wb_adr_i == ADR_EXT_EN) | (wb_adr_i == ADR_EXT_PRI));

	// Read multiplexer; unmapped addresses read zero and still ack.
	always_comb begin
		rd_byte = REG_RESET;
		unique case (wb_adr_i)
			ADR_TIMER_CTRL: begin
				rd_byte               = REG_RESET;
				rd_byte[TC_EXT0_TYPE] = ext_type_q[0];
				rd_byte[TC_EXT0_FLAG] = ext_flag_q[0];
				rd_byte[TC_EXT1_TYPE] = ext_type_q[1];
				rd_byte[TC_EXT1_FLAG] = ext_flag_q[1];
				rd_byte[TC_TIMER0]    = timer0_flag_i;
				rd_byte[TC_TIMER1]    = timer1_flag_i;
			end
			ADR_EXT_FLAG: rd_byte = {xflag_q, REG_RESET[EXF_LSB-1:0]} | EXT_FLAG_RSVD;
			ADR_EXT_CTRL: begin
				rd_byte          = EXT_CTRL_RSVD;
				rd_byte[XC_WAKE] = wake_flag_q;
			end
			ADR_BASIC_EN:  rd_byte = basic_enable_register_q;
			ADR_BASIC_PRI: rd_byte = basic_priority_register_q | BASIC_PRI_RSVD;
			ADR_EXT_EN:    rd_byte = extended_interrupt_enable_q | EXT_EN_RSVD;
			ADR_EXT_PRI:   rd_byte = extended_interrupt_priority_q | EXT_PRI_RSVD;
			default:       rd_byte = REG_RESET;
		endcase
	end

	// Acknowledge and registered read data.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end else begin
			ack_q <= wb_req;
			dat_q <= (wb_req & ~wb_we_i) ? {{(WB_DW - REG_W){1'b0}}, rd_byte} : '0;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// ----------------------------------------------------------------
	// Enable and priority registers
	// ----------------------------------------------------------------

	// All writable enable and level bits start cleared.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			basic_enable_register_q       <= REG_RESET;
			basic_priority_register_q     <= REG_RESET;
			extended_interrupt_enable_q   <= REG_RESET;
			extended_interrupt_priority_q <= REG_RESET;
		end else if (wr_en) begin
			if (wb_adr_i == ADR_BASIC_EN) begin
				basic_enable_register_q <= wdat & BASIC_EN_WMASK;
			end
			if (wb_adr_i == ADR_BASIC_PRI) begin
				basic_priority_register_q <= wdat & BASIC_PRI_WMASK;
			end
			if (wb_adr_i == ADR_EXT_EN) begin
				extended_interrupt_enable_q <= wdat & EXT_WMASK;
			end
			if (wb_adr_i == ADR_EXT_PRI) begin
				extended_interrupt_priority_q <= wdat & EXT_WMASK;
			end
		end
	end

	// ----------------------------------------------------------------
	// External pins
	// ----------------------------------------------------------------

	// Two-flop synchronisers; only the second stage is looked at.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pin_meta_q <= '1;
			pin_sync_q <= '1;
		end else begin
			pin_meta_q <= {ext_irq1_pin_n, ext_irq0_pin_n};
			pin_sync_q <= pin_meta_q;
		end
	end

	// Edge-type pins whose last sample was high and whose current one is low.
	assign ext_fall = ext_type_q & pin_prev_q & ~pin_sync_q;

	// Type bits and pending flags; a pin is sampled only on the phase strobe.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pin_prev_q <= '1;
			ext_type_q <= '0;
			ext_flag_q <= '0;
		end else begin
			if (fourth_clock_phase) begin
				pin_prev_q <= pin_sync_q;
			end
			if (wr_en && wb_adr_i == ADR_TIMER_CTRL) begin
				ext_type_q[0] <= wdat[TC_EXT0_TYPE];
				ext_type_q[1] <= wdat[TC_EXT1_TYPE];
			end
			for (int i = 0; i < NEXT; i++) begin
				if (fourth_clock_phase && !ext_type_q[i]) begin
					ext_flag_q[i] <= ~pin_sync_q[i];
				end else if (fourth_clock_phase && pin_prev_q[i] && !pin_sync_q[i]) begin
					ext_flag_q[i] <= 1'b1;
				end else if (irq_take_i && ext_type_q[i]
					&& src_q == (i == 0 ? SRC_EXT0 : SRC_EXT1)) begin
					ext_flag_q[i] <= 1'b0;
				end else if (wr_en && wb_adr_i == ADR_TIMER_CTRL) begin
					ext_flag_q[i] <= wdat[i == 0 ? TC_EXT0_FLAG : TC_EXT1_FLAG];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Extended source flags
	// ----------------------------------------------------------------
	assign xsrc_now = {radio_ready_two_i, radio_ready_one_i, spi_ready_i, adc_eoc_i};
	assign xrise    = xsrc_now & ~xsrc_prev_q;

	// Rising edges set the extended flags, a high wakeup event sets the wakeup flag; a set in the same cycle beats a clear.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			xsrc_prev_q <= '0;
			xflag_q     <= '0;
			wake_flag_q <= 1'b0;
		end else begin
			xsrc_prev_q <= xsrc_now;
			if (wr_en && wb_adr_i == ADR_EXT_FLAG) begin
				xflag_q <= xrise | wdat[REG_W-1:EXF_LSB];
			end else begin
				xflag_q <= xrise | xflag_q;
			end
			if (wr_en && wb_adr_i == ADR_EXT_CTRL) begin
				wake_flag_q <= wakeup_evt_i | wdat[XC_WAKE];
			end else begin
				wake_flag_q <= wakeup_evt_i | wake_flag_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Masking and arbitration
	// ----------------------------------------------------------------

	// Pending, enable and level vectors in natural order.
	assign pend      = {wake_flag_q, xflag_q, timer2_flag_i, serial_flag_i, timer1_flag_i,
		ext_flag_q[1], timer0_flag_i, ext_flag_q[0]};
	assign en_all    = {extended_interrupt_enable_q[EXT_SRCS-1:0],
		basic_enable_register_q[BASIC_SRCS-1:0]};
	assign lvl_all   = {extended_interrupt_priority_q[EXT_SRCS-1:0],
		basic_priority_register_q[BASIC_SRCS-1:0]};
	assign global_en = basic_enable_register_q[BE_GLOBAL];

	// Only a strictly higher level may preempt the running routine.
	assign cand_hi = (global_en && !act_hi_q) ? (pend & en_all & lvl_all) : '0;
	assign cand_lo = (global_en && !act_hi_q && !act_lo_q)
		? (pend & en_all & ~lvl_all) : '0;

	// Return or mask writes delay service by one extra instruction.
	assign hold_ev = reti_i | mask_wr;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			hold_q <= 1'b0;
		end else if (hold_ev) begin
			hold_q <= 1'b1;
		end else if (instr_done_i) begin
			hold_q <= 1'b0;
		end
	end

	// Request decided at each instruction boundary, high level first.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			req_q <= 1'b0;
			lvl_q <= 1'b0;
			src_q <= SRC_EXT0;
			vec_q <= VEC_NONE;
		end else if (irq_take_i) begin
			req_q <= 1'b0;
		end else if (instr_done_i) begin
			if (hold_q || hold_ev) begin
				req_q <= 1'b0;
			end else if (|cand_hi) begin
				req_q <= 1'b1;
				lvl_q <= 1'b1;
				src_q <= pick_lowest(cand_hi);
				vec_q <= vec_of(pick_lowest(cand_hi));
			end else if (|cand_lo) begin
				req_q <= 1'b1;
				lvl_q <= 1'b0;
				src_q <= pick_lowest(cand_lo);
				vec_q <= vec_of(pick_lowest(cand_lo));
			end else begin
				req_q <= 1'b0;
			end
		end else if (!global_en) begin
			req_q <= 1'b0;
		end
	end

	// Active levels: taken on acceptance, the top one freed on return.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			act_hi_q <= 1'b0;
			act_lo_q <= 1'b0;
		end else if (irq_take_i && req_q) begin
			if (lvl_q) begin
				act_hi_q <= 1'b1;
			end else begin
				act_lo_q <= 1'b1;
			end
		end else if (reti_i) begin
			if (act_hi_q) begin
				act_hi_q <= 1'b0;
			end else begin
				act_lo_q <= 1'b0;
			end
		end
	end

	assign irq_req_o    = req_q;
	assign irq_vector_o = vec_q;
	assign irq_level_o  = lvl_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking tlic_cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	a_reserved_ones: assert property (
		(wb_ack_o && !wb_we_i && (wb_adr_i == ADR_EXT_EN || wb_adr_i == ADR_EXT_PRI))
		|-> (wb_dat_o[7:5] == 3'b111))
		else $error("Reserved enable or priority bits did not read one.");

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Wishbone ack stood longer than one cycle.");

	a_vector_match: assert property (irq_req_o |-> (irq_vector_o == vec_of(src_q)))
		else $error("Vector does not match the chosen source.");

	a_high_first: assert property (
		(instr_done_i && !irq_take_i && !hold_q && !hold_ev && (|cand_hi))
		|=> (irq_req_o && irq_level_o))
		else $error("Pending high-level request was not chosen.");

	a_global_mask: assert property ((!global_en && !instr_done_i) |=> !irq_req_o)
		else $error("Request raised while global enable is clear.");

	a_hold_extra: assert property ((instr_done_i && (hold_q || hold_ev)) |=> !irq_req_o)
		else $error("Request made without the extra instruction.");

	a_wake_gate: assert property (
		(instr_done_i && !extended_interrupt_enable_q[SRC_WAKE - BASIC_SRCS])
		|=> !(irq_req_o && src_q == SRC_WAKE))
		else $error("Wakeup requested while its enable is clear.");

	a_edge_detect: assert property (
		(fourth_clock_phase && (ext_fall != '0))
		|=> ((ext_flag_q & $past(ext_fall)) == $past(ext_fall)))
		else $error("Falling edge on an external pin was missed.");

	a_level_follow: assert property (
		(fourth_clock_phase && !ext_type_q[0]) |=> (ext_flag_q[0] == !$past(pin_sync_q[0])))
		else $error("Level flag does not follow the pin sample.");

	a_flag_rise: assert property ($rose(adc_eoc_i) |=> ##1 xflag_q[0])
		else $error("ADC rising edge did not set its flag.");

	a_take_level: assert property ((irq_take_i && req_q && lvl_q) |=> act_hi_q[*2])
		else $error("High level not held after acceptance.");

	a_reti_release: assert property ((reti_i && !irq_take_i && act_hi_q) |=> !act_hi_q)
		else $error("Return did not release the high level.");

endmodule : tlic_top

`default_nettype wire

// File: tlic_pkg.sv
// Constants shared by the two-level interrupt controller.
package tlic_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned NSRC     = 11;
	localparam int unsigned NEXT     = 2;
	localparam int unsigned NXSRC    = 4;
	localparam int unsigned SRC_W    = 4;
	localparam int unsigned REG_W    = 8;
	localparam int unsigned ADR_W    = 8;
	localparam int unsigned WB_DW    = 32;

	typedef logic [SRC_W-1:0] tlic_src_t;
	typedef logic [REG_W-1:0] tlic_byte_t;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [ADR_W-1:0] ADR_TIMER_CTRL = 8'h88;
	localparam logic [ADR_W-1:0] ADR_EXT_FLAG   = 8'h90;
	localparam logic [ADR_W-1:0] ADR_BASIC_EN   = 8'ha8;
	localparam logic [ADR_W-1:0] ADR_BASIC_PRI  = 8'hb8;
	localparam logic [ADR_W-1:0] ADR_EXT_CTRL   = 8'hd8;
	localparam logic [ADR_W-1:0] ADR_EXT_EN     = 8'he8;
	localparam logic [ADR_W-1:0] ADR_EXT_PRI    = 8'hf8;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned TC_EXT0_TYPE  = 0;
	localparam int unsigned TC_EXT0_FLAG  = 1;
	localparam int unsigned TC_EXT1_TYPE  = 2;
	localparam int unsigned TC_EXT1_FLAG  = 3;
	localparam int unsigned TC_TIMER0     = 5;
	localparam int unsigned TC_TIMER1     = 7;
	localparam int unsigned BE_GLOBAL     = 7;
	localparam int unsigned EXF_LSB       = 4;
	localparam int unsigned XC_WAKE       = 3;
	localparam int unsigned BASIC_SRCS    = 6;
	localparam int unsigned EXT_SRCS      = 5;

	// ----------------------------------------------------------------
	// Reserved read values, write masks and reset values
	// ----------------------------------------------------------------
	localparam tlic_byte_t EXT_EN_RSVD     = 8'he0;
	localparam tlic_byte_t EXT_PRI_RSVD    = 8'he0;
	localparam tlic_byte_t BASIC_PRI_RSVD  = 8'h80;
	localparam tlic_byte_t EXT_FLAG_RSVD   = 8'h08;
	localparam tlic_byte_t EXT_CTRL_RSVD   = 8'h40;
	localparam tlic_byte_t BASIC_EN_WMASK  = 8'hbf;
	localparam tlic_byte_t BASIC_PRI_WMASK = 8'h3f;
	localparam tlic_byte_t EXT_WMASK       = 8'h1f;
	localparam tlic_byte_t REG_RESET       = 8'h00;

	// ----------------------------------------------------------------
	// Source indices in natural order and their vectors
	// ----------------------------------------------------------------
	localparam tlic_src_t SRC_EXT0 = 4'h0;
	localparam tlic_src_t SRC_TMR0 = 4'h1;
	localparam tlic_src_t SRC_EXT1 = 4'h2;
	localparam tlic_src_t SRC_TMR1 = 4'h3;
	localparam tlic_src_t SRC_SER  = 4'h4;
	localparam tlic_src_t SRC_TMR2 = 4'h5;
	localparam tlic_src_t SRC_ADC  = 4'h6;
	localparam tlic_src_t SRC_SPI  = 4'h7;
	localparam tlic_src_t SRC_RAD1 = 4'h8;
	localparam tlic_src_t SRC_RAD2 = 4'h9;
	localparam tlic_src_t SRC_WAKE = 4'ha;

	localparam tlic_byte_t VEC_EXT0 = 8'h03;
	localparam tlic_byte_t VEC_TMR0 = 8'h0b;
	localparam tlic_byte_t VEC_EXT1 = 8'h13;
	localparam tlic_byte_t VEC_TMR1 = 8'h1b;
	localparam tlic_byte_t VEC_SER  = 8'h23;
	localparam tlic_byte_t VEC_TMR2 = 8'h2b;
	localparam tlic_byte_t VEC_ADC  = 8'h43;
	localparam tlic_byte_t VEC_SPI  = 8'h4b;
	localparam tlic_byte_t VEC_RAD1 = 8'h53;
	localparam tlic_byte_t VEC_RAD2 = 8'h5b;
	localparam tlic_byte_t VEC_WAKE = 8'h63;
	localparam tlic_byte_t VEC_NONE = 8'h00;

endpackage : tlic_pkg

// File: tlic_cpu_model.sv
// CPU core model: instruction cycles, sample strobe, interrupt accept and return.
`timescale 1ns/1ps
`default_nettype none

module tlic_cpu_model (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic arst_n,
	// Bench control
	input  wire logic take_en,
	input  wire logic reti_cmd,
	// Controller side
	input  wire logic irq_req,
	output logic      fourth_clock_phase,
	output logic      instr_done,
	output logic      irq_take,
	output logic      reti
);
	logic [1:0] phase_q;

	// Four clocks to an instruction cycle; the last one ends it.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end
	assign fourth_clock_phase = (phase_q == 2'h3);
	assign instr_done         = (phase_q == 2'h3);

	// Accept only a standing request, one pulse per request; return on command.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irq_take <= 1'b0;
			reti     <= 1'b0;
		end else begin
			irq_take <= take_en & irq_req & ~irq_take;
			reti     <= reti_cmd;
		end
	end
endmodule : tlic_cpu_model
`default_nettype wire

// File: tlic_top_tb.sv
// Self-checking bench for the two-level interrupt controller.
`timescale 1ns/1ps
`default_nettype none

module tlic_top_tb;
	import tlic_pkg::*;
	logic        clk_sys, arst_n, cyc, stb, we, ack, req, lvl;
	logic        fcp, idone, take, reti, take_en, reti_cmd, pin0, pin1, wake;
	logic [7:0]  adr, vec, rd;
	logic [3:0]  sel, tflag, xsrc;
	logic [31:0] dat_w, dat_r;
	int          num_errors, total_checks;
	logic [7:0]  vecs [5] = '{VEC_ADC, VEC_SPI, VEC_RAD1, VEC_RAD2, VEC_WAKE};

	tlic_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
		.wb_ack_o(ack), .fourth_clock_phase(fcp), .instr_done_i(idone), .irq_take_i(take),
		.reti_i(reti), .irq_req_o(req), .irq_vector_o(vec), .irq_level_o(lvl),
		.ext_irq0_pin_n(pin0), .ext_irq1_pin_n(pin1), .timer0_flag_i(tflag[0]),
		.timer1_flag_i(tflag[1]), .serial_flag_i(tflag[2]), .timer2_flag_i(tflag[3]),
		.adc_eoc_i(xsrc[0]), .spi_ready_i(xsrc[1]), .radio_ready_one_i(xsrc[2]),
		.radio_ready_two_i(xsrc[3]), .wakeup_evt_i(wake));
	tlic_cpu_model cpu (.clk_sys(clk_sys), .arst_n(arst_n), .take_en(take_en),
		.reti_cmd(reti_cmd), .irq_req(req), .fourth_clock_phase(fcp), .instr_done(idone),
		.irq_take(take), .reti(reti));

	// Free-running system clock.
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic wrap_up();
		if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask : chk

	// One classic Wishbone cycle; read data lands in rd.
	task automatic wb(bit w, logic [7:0] a, logic [7:0] d);
		int n;
		@(posedge clk_sys);
		{cyc, stb, we, adr, sel, dat_w} <= {1'b1, 1'b1, w, a, 4'h1, 24'h0, d};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			$display("Error wb_ack expected 1 seen 0");
			num_errors++;
			wrap_up();
		end
		rd = dat_r[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	// Let three instruction cycles pass, then judge the request lines as they stand at the edge.
	task automatic irq(logic r, logic [7:0] v, logic l);
		repeat (12) @(posedge clk_sys);
		chk("irq_req", {7'h0, r}, {7'h0, req});
		if (r) chk("irq_vector", v, vec);
		if (r) chk("irq_level", {7'h0, l}, {7'h0, lvl});
	endtask : irq

	task automatic pulse_reti();
		@(posedge clk_sys) reti_cmd <= 1'b1;
		@(posedge clk_sys) reti_cmd <= 1'b0;
	endtask : pulse_reti

	task automatic take_one();
		@(posedge clk_sys) take_en <= 1'b1;
		irq(1'b0, 8'h00, 1'b0);
		take_en <= 1'b0;
	endtask : take_one

	task automatic t_regs();
		wb(0, ADR_EXT_EN, 8'h00); chk("ext_en", 8'he0, rd);
		wb(0, ADR_EXT_PRI, 8'h00); chk("ext_pri", 8'he0, rd);
		wb(0, ADR_BASIC_EN, 8'h00); chk("basic_en", 8'h00, rd);
		wb(1, 8'h10, 8'hff); wb(0, 8'h10, 8'h00); chk("unmapped", 8'h00, rd);
		wb(1, ADR_EXT_EN, 8'h00); wb(0, ADR_EXT_EN, 8'h00); chk("ext_en", 8'he0, rd);
		wb(1, ADR_EXT_EN, 8'hff); wb(0, ADR_EXT_EN, 8'h00); chk("ext_en", 8'hff, rd);
	endtask : t_regs

	task automatic t_ext();
		wb(1, ADR_BASIC_EN, 8'h80);
		@(posedge clk_sys) {xsrc, wake} <= 5'h1f;
		@(posedge clk_sys) {xsrc, wake} <= 5'h00;
		wb(0, ADR_EXT_FLAG, 8'h00); chk("ext_flag", 8'hf8, rd);
		wb(0, ADR_EXT_CTRL, 8'h00); chk("ext_ctrl", 8'h48, rd);
		irq(1'b1, VEC_ADC, 1'b0);
		for (int i = 1; i < 5; i++) begin
			wb(1, ADR_EXT_EN, 8'h1f << i); irq(1'b1, vecs[i], 1'b0);
		end
		wb(1, ADR_EXT_EN, 8'h00); irq(1'b0, 8'h00, 1'b0);
		wb(1, ADR_EXT_EN, 8'h1f); wb(1, ADR_BASIC_EN, 8'h00); irq(1'b0, 8'h00, 1'b0);
		wb(1, ADR_BASIC_EN, 8'h80);
		wb(1, ADR_EXT_PRI, 8'h10); irq(1'b1, VEC_WAKE, 1'b1);
		for (int i = 0; i < 4; i++) begin
			wb(1, ADR_EXT_PRI, 8'h01 << i); irq(1'b1, vecs[i], 1'b1);
		end
		wb(0, ADR_EXT_PRI, 8'h00); chk("ext_pri", 8'he8, rd);
		wb(1, ADR_EXT_PRI, 8'h00); wb(1, ADR_EXT_CTRL, 8'h00);
		wb(1, ADR_EXT_FLAG, 8'h00); irq(1'b0, 8'h00, 1'b0);
		wb(1, ADR_EXT_FLAG, 8'h20); irq(1'b1, VEC_SPI, 1'b0);
	endtask : t_ext

	task automatic t_nest();
		take_one();
		wb(1, ADR_EXT_CTRL, 8'h08); irq(1'b0, 8'h00, 1'b0);
		wb(1, ADR_EXT_PRI, 8'h10); irq(1'b1, VEC_WAKE, 1'b1);
		take_one();
		wb(1, ADR_EXT_PRI, 8'h12); irq(1'b0, 8'h00, 1'b0);
		pulse_reti(); irq(1'b1, VEC_SPI, 1'b1);
		wb(1, ADR_EXT_FLAG, 8'h00); irq(1'b1, VEC_WAKE, 1'b1);
		pulse_reti();
		wb(1, ADR_EXT_FLAG, 8'h00); wb(1, ADR_EXT_CTRL, 8'h00); wb(1, ADR_EXT_PRI, 8'h00);
		irq(1'b0, 8'h00, 1'b0);
	endtask : t_nest

	task automatic t_basic();
		wb(1, ADR_BASIC_EN, 8'hbf);
		tflag <= 4'h9; irq(1'b1, VEC_TMR0, 1'b0);
		wb(1, ADR_BASIC_PRI, 8'h20); irq(1'b1, VEC_TMR2, 1'b1);
		wb(1, ADR_BASIC_PRI, 8'h00); tflag <= 4'h0;
		pin0 <= 1'b0; irq(1'b1, VEC_EXT0, 1'b0);
		wb(0, ADR_TIMER_CTRL, 8'h00); chk("timer_ctrl", 8'h02, rd);
		pin0 <= 1'b1; irq(1'b0, 8'h00, 1'b0);
		wb(1, ADR_TIMER_CTRL, 8'h04);
		pin1 <= 1'b0; irq(1'b1, VEC_EXT1, 1'b0);
		pin1 <= 1'b1; wb(0, ADR_TIMER_CTRL, 8'h00); chk("timer_ctrl", 8'h0c, rd);
	endtask : t_basic

	// Reset, then the scenarios in turn.
	initial begin
		{cyc, stb, we, adr, sel, dat_w, take_en, reti_cmd} = '0;
		{pin0, pin1, tflag, xsrc, wake, num_errors, total_checks} = {2'b11, 9'h0, 64'h0};
		arst_n = 1'b0;
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_regs();
		t_ext();
		t_nest();
		t_basic();
		wrap_up();
	end

	// Watchdog against a hung handshake.
	initial begin
		repeat (30000) @(posedge clk_sys);
		$display("Error watchdog expected done seen timeout");
		num_errors++;
		wrap_up();
	end
endmodule : tlic_top_tb
`default_nettype wire
